// *** scf_pkg.sv ***
// Overview of operation
// - Reply to a command comes next frame
// - Length must be 16, 24 or 32 clocks
// - After reset send reset-report frame first
// - Prefix 11 is a write syntax error
// - Prefix 00 read is a syntax error
// - Unmapped address access is a syntax error
// - Top bit 0, trailer not 10, requests standard diagnosis
// - Write frame updates register, replies diagnosis
// - Read frame reply echoes address and content
// - Four-bit bank plus two-bit sub select register
// - Shift one bit per serial clock
// - Act on data only at select release
// - Fault flag low for 16, 24, 32 clocks
// - First reply after reset flags fault, reports
package scf_pkg;

  localparam int FRAME_BITS = 16;
  localparam int CNT_BITS = 6;
  localparam int REG_COUNT = 3;

  // Valid transfer lengths in serial clocks, then the clock count saturation value
  localparam logic [5:0] LEN_MIN = 6'h10;
  localparam logic [5:0] LEN_MID = 6'h18;
  localparam logic [5:0] LEN_MAX = 6'h20;
  localparam logic [5:0] CNT_SAT = 6'h3f;

  // Frame field positions
  localparam int POS_TOP = 15;
  localparam int POS_SECOND = 14;
  localparam int POS_BANK_HI = 13;
  localparam int POS_BANK_LO = 10;
  localparam int POS_SUB_HI = 9;
  localparam int POS_SUB_LO = 8;
  localparam int POS_FAULT = 10;

  localparam logic [1:0] RD_PREFIX = 2'h1;
  localparam logic [1:0] WR_PREFIX = 2'h2;
  localparam logic [1:0] RD_TRAILER = 2'h2;
  localparam logic [1:0] REPLY_PREFIX = 2'h2;

  // Addresses as {register_bank_select, register_sub_select}
  localparam logic [5:0] ADDR_OUT_CTRL = 6'h00;
  localparam logic [5:0] ADDR_MAP_SEL0 = 6'h04;
  localparam logic [5:0] ADDR_MAP_SEL1 = 6'h05;
  localparam logic [5:0] ADDR_RESET_REPORT = 6'h06;
  localparam logic [5:0] ADDR_SOFT_RESET = 6'h3f;

  localparam logic [7:0] RST_OUT_CTRL = 8'h00;
  localparam logic [7:0] RST_MAP_SEL0 = 8'h04;
  localparam logic [7:0] RST_MAP_SEL1 = 8'h08;

  // Reset report contents
  localparam logic [7:0] RPT_POWER_ON = 8'h01;
  localparam logic [7:0] RPT_SOFT = 8'h02;

  localparam logic [15:0] REPLY_POWER_ON = {REPLY_PREFIX, ADDR_RESET_REPORT, RPT_POWER_ON};
  localparam logic [15:0] REPLY_SOFT = {REPLY_PREFIX, ADDR_RESET_REPORT, RPT_SOFT};
  localparam logic [15:0] REPLY_SYNTAX = 16'hbf00;

  // Filtered pin idle levels {frame_select_n, sclk, sdi}
  localparam logic [2:0] PIN_IDLE = 3'h4;

endpackage

// *** scf_spi_command_frame_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module scf_spi_command_frame_slave (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic frame_select_n,
  input wire logic sdi,
  input wire logic uv_vs,
  input wire logic lop_vdd,
  input wire logic [1:0] op_mode,
  input wire logic open_load_off,
  input wire logic [7:0] chan_fault,
  output logic sdo,
  output logic sdo_oe_n,
  output logic [7:0] out_ctrl,
  output logic [7:0] map_sel0,
  output logic [7:0] map_sel1,
  output logic transfer_fault_flag
);

  // Pin synchroniser and glitch filter
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [2:0] pin_s3_reg;
  logic [2:0] pin_q_reg;
  logic [2:0] pin_q_next;
  logic [2:0] pin_d_reg;

  logic [15:0] shift_reg;
  logic [5:0] bit_cnt_reg;
  logic [15:0] reply_reg;
  logic [15:0] reply_next;
  logic sdo_reg;
  logic sdo_oe_n_reg;
  logic fault_reg;
  logic [7:0] rpt_reg;
  logic [7:0] regs_reg [0:scf_pkg::REG_COUNT-1];

  assign pin_q_next = ((pin_s2_reg ~^ pin_s3_reg) & pin_s3_reg)
                    | ((pin_s2_reg ^ pin_s3_reg) & pin_q_reg);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= scf_pkg::PIN_IDLE;
      pin_s2_reg <= scf_pkg::PIN_IDLE;
      pin_s3_reg <= scf_pkg::PIN_IDLE;
      pin_q_reg <= scf_pkg::PIN_IDLE;
      pin_d_reg <= scf_pkg::PIN_IDLE;
    end else begin
      pin_s1_reg <= {frame_select_n, sclk, sdi};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_q_reg <= pin_q_next;
      pin_d_reg <= pin_q_reg;
    end
  end

  wire csn_q = pin_q_reg[2];
  wire sclk_q = pin_q_reg[1];
  wire sdi_q = pin_q_reg[0];
  wire frame_start = pin_d_reg[2] & ~csn_q;
  wire frame_end = ~pin_d_reg[2] & csn_q;
  wire sclk_rise = ~csn_q & ~pin_d_reg[1] & sclk_q;
  wire sclk_fall = ~csn_q & pin_d_reg[1] & ~sclk_q;

  // Command decode of the last sixteen bits shifted in
  wire [15:0] cmd = shift_reg;
  wire [5:0] cmd_addr = cmd[scf_pkg::POS_BANK_HI:scf_pkg::POS_SUB_LO];
  wire len_ok = (bit_cnt_reg == scf_pkg::LEN_MIN) | (bit_cnt_reg == scf_pkg::LEN_MID)
              | (bit_cnt_reg == scf_pkg::LEN_MAX);
  wire rd_frame = ~cmd[scf_pkg::POS_TOP] & (cmd[1:0] == scf_pkg::RD_TRAILER);
  wire wr_frame = cmd[scf_pkg::POS_TOP];
  wire rd_prefix_ok = cmd[15:14] == scf_pkg::RD_PREFIX;
  wire wr_prefix_ok = cmd[15:14] == scf_pkg::WR_PREFIX;
  wire hit_out = cmd_addr == scf_pkg::ADDR_OUT_CTRL;
  wire hit_map0 = cmd_addr == scf_pkg::ADDR_MAP_SEL0;
  wire hit_map1 = cmd_addr == scf_pkg::ADDR_MAP_SEL1;
  wire hit_rpt = cmd_addr == scf_pkg::ADDR_RESET_REPORT;
  wire hit_swr = cmd_addr == scf_pkg::ADDR_SOFT_RESET;
  wire hit_rw = hit_out | hit_map0 | hit_map1;
  wire [1:0] reg_idx = hit_map1 ? 2'h2 : (hit_map0 ? 2'h1 : 2'h0);
  wire rd_ok = rd_frame & rd_prefix_ok & (hit_rw | hit_rpt);
  wire wr_ok = wr_frame & wr_prefix_ok & hit_rw;
  wire swr_ok = wr_frame & wr_prefix_ok & hit_swr;
  wire syntax_err = (rd_frame & ~rd_ok) | (wr_frame & ~wr_ok & ~swr_ok);
  wire diag_req = ~cmd[scf_pkg::POS_TOP] & ~rd_frame;
  wire [7:0] rd_data = hit_rpt ? rpt_reg : regs_reg[reg_idx];
  wire [15:0] diag_word = {1'b0, uv_vs, lop_vdd, op_mode, ~len_ok, 1'b0,
                           open_load_off, chan_fault};
  wire do_write = frame_end & len_ok & wr_ok;
  wire do_swr = frame_end & len_ok & swr_ok;

  always_comb begin
    if (!len_ok) begin
      reply_next = diag_word;
    end else if (swr_ok) begin
      reply_next = scf_pkg::REPLY_SOFT;
    end else if (syntax_err) begin
      reply_next = scf_pkg::REPLY_SYNTAX;
    end else if (rd_ok) begin
      reply_next = {scf_pkg::REPLY_PREFIX, cmd_addr, rd_data};
    end else begin
      reply_next = diag_word;
    end
  end

  // Serial shifter: sample on falling clock, present on rising
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_reg <= 16'h0000;
      bit_cnt_reg <= 6'h00;
      sdo_reg <= 1'b0;
    end else if (frame_start) begin
      shift_reg <= reply_reg;
      bit_cnt_reg <= 6'h00;
      sdo_reg <= reply_reg[scf_pkg::POS_TOP];
    end else if (sclk_fall) begin
      shift_reg <= {shift_reg[14:0], sdi_q};
      if (bit_cnt_reg != scf_pkg::CNT_SAT) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
    end else if (sclk_rise) begin
      sdo_reg <= shift_reg[scf_pkg::POS_TOP];
    end
  end

  // Reset reply pending until the first frame fetches it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reply_reg <= scf_pkg::REPLY_POWER_ON;
      fault_reg <= 1'b1;
      sdo_oe_n_reg <= 1'b1;
    end else begin
      sdo_oe_n_reg <= csn_q;
      if (frame_end) begin
        reply_reg <= reply_next;
        fault_reg <= ~len_ok;
      end
    end
  end

  // Register bank; errors discard the command untouched
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regs_reg[0] <= scf_pkg::RST_OUT_CTRL;
      regs_reg[1] <= scf_pkg::RST_MAP_SEL0;
      regs_reg[2] <= scf_pkg::RST_MAP_SEL1;
      rpt_reg <= scf_pkg::RPT_POWER_ON;
    end else if (do_swr) begin
      regs_reg[0] <= scf_pkg::RST_OUT_CTRL;
      regs_reg[1] <= scf_pkg::RST_MAP_SEL0;
      regs_reg[2] <= scf_pkg::RST_MAP_SEL1;
      rpt_reg <= scf_pkg::RPT_SOFT;
    end else if (do_write) begin
      regs_reg[reg_idx] <= cmd[7:0];
    end
  end

  assign sdo = sdo_reg;
  assign sdo_oe_n = sdo_oe_n_reg;
  assign out_ctrl = regs_reg[0];
  assign map_sel0 = regs_reg[1];
  assign map_sel1 = regs_reg[2];
  assign transfer_fault_flag = fault_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence frame_closes;
    frame_end;
  endsequence

  sequence good_length;
    frame_closes ##0 len_ok;
  endsequence

  property reply_loaded;
    frame_start |=> shift_reg == $past(reply_reg);
  endproperty

  reply_next_frame_a: assert property (reply_loaded)
    else $error("reply not loaded at frame start");

  length_fault_a: assert property (frame_closes ##0 !len_ok |=> fault_reg && reply_reg[10])
    else $error("bad length not flagged");

  length_ok_a: assert property (good_length ##0 diag_req |=> !fault_reg && !reply_reg[10])
    else $error("good length flagged as fault");

  soft_reset_reply_a: assert property (good_length ##0 swr_ok
      |=> reply_reg == scf_pkg::REPLY_SOFT && out_ctrl == scf_pkg::RST_OUT_CTRL)
    else $error("soft reset reply missing");

  write_syntax_a: assert property (good_length ##0 cmd[15:14] == 2'h3
      |=> reply_reg == scf_pkg::REPLY_SYNTAX)
    else $error("write prefix 11 accepted");

  read_syntax_a: assert property (good_length ##0 rd_frame && !cmd[14]
      |=> reply_reg == scf_pkg::REPLY_SYNTAX)
    else $error("read prefix 00 accepted");

  unmapped_addr_a: assert property (good_length ##0 wr_frame && !cmd[14] && !hit_rw && !hit_swr
      |=> reply_reg == scf_pkg::REPLY_SYNTAX)
    else $error("unmapped address accepted");

  diag_reply_a: assert property (good_length ##0 diag_req
      |=> reply_reg[15] == 1'b0 && reply_reg[7:0] == $past(chan_fault))
    else $error("diagnosis reply wrong");

  write_update_a: assert property (good_length ##0 wr_ok && hit_out
      |=> out_ctrl == $past(cmd[7:0]) && !reply_reg[15])
    else $error("write not applied");

  read_reply_a: assert property (good_length ##0 rd_ok
      |=> reply_reg[15:8] == {scf_pkg::REPLY_PREFIX, $past(cmd_addr)})
    else $error("read reply header wrong");

  shift_in_a: assert property (sclk_fall && !frame_start
      |=> shift_reg == {$past(shift_reg[14:0]), $past(sdi_q)})
    else $error("shift in wrong");

  hold_mid_frame_a: assert property (!frame_end |=> $stable(out_ctrl) && $stable(reply_reg))
    else $error("change outside frame end");

  error_discard_a: assert property (frame_closes ##0 (!len_ok || syntax_err)
      |=> $stable(out_ctrl) && $stable(map_sel0) && $stable(map_sel1))
    else $error("erroneous frame changed registers");

  sequence frame_opens;
    frame_start;
  endsequence

  sequence bit_presented;
    sclk_rise && !frame_start;
  endsequence

  sequence bit_taken;
    sclk_fall && !frame_start;
  endsequence

  sdo_first_bit_a: assert property (frame_opens
      |=> !sdo_oe_n && sdo == $past(reply_reg[scf_pkg::POS_TOP]))
    else $error("first reply bit not presented");

  sdo_release_a: assert property (frame_closes |=> sdo_oe_n)
    else $error("serial output still driven after frame");

  sdo_shift_a: assert property (bit_presented
      |=> sdo == $past(shift_reg[scf_pkg::POS_TOP]))
    else $error("serial output bit wrong");

  count_clear_a: assert property (frame_opens |=> bit_cnt_reg == 6'h00)
    else $error("clock count not cleared");

  count_step_a: assert property (bit_taken ##0 bit_cnt_reg != scf_pkg::CNT_SAT
      |=> bit_cnt_reg == $past(bit_cnt_reg) + 6'h01)
    else $error("clock count not advanced");

  count_idle_a: assert property (!frame_start && !sclk_fall |=> $stable(bit_cnt_reg))
    else $error("clock count moved without a clock");

  syntax_no_fault_a: assert property (good_length ##0 syntax_err
      |=> !transfer_fault_flag)
    else $error("syntax error flagged as length fault");

  length_diag_a: assert property (frame_closes ##0 !len_ok
      |=> !reply_reg[scf_pkg::POS_TOP] && reply_reg[7:0] == $past(chan_fault))
    else $error("bad length reply is not diagnosis");

  read_out_ctrl_a: assert property (good_length ##0 rd_ok && hit_out
      |=> reply_reg[7:0] == out_ctrl)
    else $error("output control read content wrong");

  read_map0_a: assert property (good_length ##0 rd_ok && hit_map0
      |=> reply_reg[7:0] == map_sel0)
    else $error("first map read content wrong");

  read_map1_a: assert property (good_length ##0 rd_ok && hit_map1
      |=> reply_reg[7:0] == map_sel1)
    else $error("second map read content wrong");

  read_report_a: assert property (good_length ##0 rd_ok && hit_rpt
      |=> reply_reg[7:0] == rpt_reg)
    else $error("reset report read content wrong");

  write_map0_a: assert property (good_length ##0 wr_ok && hit_map0
      |=> map_sel0 == $past(cmd[7:0]))
    else $error("first map write not applied");

  write_map1_a: assert property (good_length ##0 wr_ok && hit_map1
      |=> map_sel1 == $past(cmd[7:0]))
    else $error("second map write not applied");

  write_diag_a: assert property (good_length ##0 wr_ok
      |=> !reply_reg[scf_pkg::POS_TOP] && !reply_reg[scf_pkg::POS_FAULT])
    else $error("write reply is not clean diagnosis");

  soft_defaults_a: assert property (good_length ##0 swr_ok
      |=> map_sel0 == scf_pkg::RST_MAP_SEL0 && map_sel1 == scf_pkg::RST_MAP_SEL1
          && rpt_reg == scf_pkg::RPT_SOFT)
    else $error("soft reset left registers set");

  reg_hold_a: assert property (!frame_end |=> $stable(map_sel0) && $stable(map_sel1)
      && $stable(transfer_fault_flag))
    else $error("map or fault flag changed mid frame");

  sclk_filter_a: assert property (pin_s2_reg[1] != pin_s3_reg[1] |=> $stable(sclk_q))
    else $error("unsettled clock pin passed filter");

endmodule
`default_nettype wire

// *** scf_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module scf_host_model (
  input wire logic clk_sys,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  output logic sclk,
  output logic frame_select_n,
  output logic sdi
);
  initial begin
    sclk = 1'b0;
    frame_select_n = 1'b1;
    sdi = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Sdi moves two cycles after a fall so the filtered copy never races the sampling edge
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    wait_cyc(1);
    frame_select_n = 1'b0;
    wait_cyc(10);
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      wait_cyc(2);
      sclk = 1'b1;
      wait_cyc(4);
      sclk = 1'b0;
      wait_cyc(2);
      // Sdo settles some cycles after a rise, so it is read once the pulse is over
      rx = {rx[30:0], (sdo_oe_n === 1'b0) ? sdo : 1'bx};
    end
    wait_cyc(8);
    frame_select_n = 1'b1;
    sdi = ~sdi;
    wait_cyc(14);
  endtask
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic uv_vs = 1'b1;
  logic lop_vdd = 1'b0;
  logic [1:0] op_mode = 2'h2;
  logic open_load_off = 1'b1;
  logic [7:0] chan_fault = 8'h3c;
  logic sclk, frame_select_n, sdi, sdo, sdo_oe_n, transfer_fault_flag;
  logic [7:0] out_ctrl, map_sel0, map_sel1;
  logic [31:0] rx;
  logic [15:0] pend;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #50 clk_sys = ~clk_sys;

  scf_spi_command_frame_slave u_dut (
    .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .frame_select_n(frame_select_n), .sdi(sdi),
    .uv_vs(uv_vs), .lop_vdd(lop_vdd), .op_mode(op_mode), .open_load_off(open_load_off),
    .chan_fault(chan_fault), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .out_ctrl(out_ctrl),
    .map_sel0(map_sel0), .map_sel1(map_sel1), .transfer_fault_flag(transfer_fault_flag)
  );

  scf_host_model u_host (
    .clk_sys(clk_sys), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .sclk(sclk),
    .frame_select_n(frame_select_n), .sdi(sdi)
  );

  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] diag(input logic fault);
    return {1'b0, uv_vs, lop_vdd, op_mode, fault, 1'b0, open_load_off, chan_fault};
  endfunction

  // Reply seen now belongs to the command of the previous frame
  task automatic xf(input int n, input logic [31:0] tx, input logic [15:0] nxt);
    u_host.xfer(n, tx, rx);
    check(rx[n-1 -: 16], pend);
    check({15'h0, sdo_oe_n}, 16'h1);
    pend = nxt;
  endtask

  task automatic t_reset;
    check({out_ctrl, map_sel0}, {scf_pkg::RST_OUT_CTRL, scf_pkg::RST_MAP_SEL0});
    check({7'h0, transfer_fault_flag, map_sel1}, {8'h1, scf_pkg::RST_MAP_SEL1});
    pend = scf_pkg::REPLY_POWER_ON;
    xf(16, 32'h0, diag(1'b0));
    xf(16, 32'h0, diag(1'b0));
    check({15'h0, transfer_fault_flag}, 16'h0);
    $display("test reset done");
  endtask

  task automatic t_regs;
    logic [5:0] adr [3];
    logic [7:0] dat [3];
    logic [7:0] got [3];
    adr = '{scf_pkg::ADDR_OUT_CTRL, scf_pkg::ADDR_MAP_SEL0, scf_pkg::ADDR_MAP_SEL1};
    dat = '{8'ha5, 8'h5a, 8'hc3};
    for (int i = 0; i < 3; i++) begin
      xf(16, {16'h0, 2'b10, adr[i], dat[i]}, diag(1'b0));
      got = '{out_ctrl, map_sel0, map_sel1};
      check({8'h0, got[i]}, {8'h0, dat[i]});
      xf(16, {16'h0, 2'b01, adr[i], 6'h15, 2'b10}, {2'b10, adr[i], dat[i]});
    end
    xf(16, {16'h0, 2'b01, scf_pkg::ADDR_RESET_REPORT, 8'h02},
       {2'b10, scf_pkg::ADDR_RESET_REPORT, scf_pkg::RPT_POWER_ON});
    $display("test registers done");
  endtask

  task automatic t_syntax;
    xf(16, {16'h0, 2'b11, scf_pkg::ADDR_OUT_CTRL, 8'h0f}, scf_pkg::REPLY_SYNTAX);
    xf(16, {16'h0, 2'b00, scf_pkg::ADDR_OUT_CTRL, 8'h02}, scf_pkg::REPLY_SYNTAX);
    xf(16, {16'h0, 2'b01, 6'h08, 8'h02}, scf_pkg::REPLY_SYNTAX);
    xf(16, {16'h0, 2'b10, 6'h08, 8'h11}, scf_pkg::REPLY_SYNTAX);
    xf(16, 32'h0, diag(1'b0));
    check({8'h0, out_ctrl}, 16'h00a5);
    $display("test syntax done");
  endtask

  task automatic t_length;
    int bad [5];
    bad = '{8, 12, 15, 17, 31};
    foreach (bad[i]) begin
      u_host.xfer(bad[i], 32'h0000_80ff, rx);
      pend = diag(1'b1);
      check({15'h0, transfer_fault_flag}, 16'h1);
      check({8'h0, out_ctrl}, 16'h00a5);
    end
    xf(24, {8'h3c, 16'h8066}, diag(1'b0));
    check({8'h0, out_ctrl}, 16'h0066);
    xf(32, {16'h1234, 16'h8099}, diag(1'b0));
    check(rx[15:0], 16'h1234);
    check({7'h0, transfer_fault_flag, out_ctrl}, 16'h0099);
    $display("test length done");
  endtask

  task automatic t_soft;
    xf(16, {16'h0, 2'b10, scf_pkg::ADDR_SOFT_RESET, 8'h00}, scf_pkg::REPLY_SOFT);
    check({out_ctrl, map_sel1}, {scf_pkg::RST_OUT_CTRL, scf_pkg::RST_MAP_SEL1});
    xf(16, 32'h0, diag(1'b0));
    xf(16, {16'h0, 2'b01, scf_pkg::ADDR_RESET_REPORT, 8'h02},
       {2'b10, scf_pkg::ADDR_RESET_REPORT, scf_pkg::RPT_SOFT});
    xf(16, 32'h0, diag(1'b0));
    $display("test soft reset done");
  endtask

  // About 25 frames of some 170 cycles each fit well inside this ceiling
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test;
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    repeat (6) @(negedge clk_sys);
    t_reset;
    t_regs;
    t_syntax;
    t_length;
    t_soft;
    finish_test;
  end
endmodule
`default_nettype wire
